/* verilog/wlvl_pkg.sv */
// Constants for the write leveling block of a x16 DDR3 device.
// Assumes one 200 MHz clock; leveling timings are given in ns.
package wlvl_pkg;
  localparam int unsigned ClockMhz = 200;
  localparam int unsigned ModeDelayNs = 75;
  localparam int unsigned ModeDelayCycles =
    (ModeDelayNs * ClockMhz + 999) / 1000;
  localparam int unsigned FeedbackNs = 10;
  localparam int unsigned FeedbackCycles =
    (FeedbackNs * ClockMhz) / 1000 > 0 ?
    (FeedbackNs * ClockMhz) / 1000 : 1;
  localparam int unsigned CountWidth = 8;
  localparam int unsigned LevelBit = 7;
  localparam int unsigned QoffBit = 12;
  localparam int unsigned LaneBits = 8;
  localparam logic [15:0] KeepMask = 16'h1A66;
  localparam logic [15:0] MrOne = 16'h0000;
  localparam logic [2:0] Mr1Select = 3'h1;
  typedef enum logic [1:0] {
    ModeNormal,
    ModeLevel,
    ModeExit
  } level_mode_t;
endpackage

/* verilog/lane_if.sv */
// Per-lane strobe sampling signals between top and lane module.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface lane_if;
  logic strobe;
  logic clockLevel;
  logic enable;
  logic outputsOn;
  logic [7:0] dqOut;
  logic [7:0] dqOe;
  modport top (output strobe, output clockLevel, output enable,
    output outputsOn, input dqOut, input dqOe);
  modport lane (input strobe, input clockLevel, input enable,
    input outputsOn, output dqOut, output dqOe);
endinterface

/* verilog/wlvl_lane.sv */
// One byte lane of leveling feedback.
// Assumes strobe and clock level already synchronised.
`timescale 1ns/1ps
module wlvl_lane #(
  parameter bit PrimeOnly = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Lane signals
  lane_if.lane lane
);
  // ---------------------------------------------------------------
  // Rising strobe edge capture
  // ---------------------------------------------------------------
  logic lastStrobe;
  logic sampled;
  logic seenEdge;
  logic [wlvl_pkg::CountWidth-1:0] waitCount;
  logic [7:0] dqReg;
  logic [7:0] oeReg;
  wire rise = lane.strobe & ~lastStrobe & lane.enable;
  wire [7:0] feedbackBits = PrimeOnly ? {7'h00, sampled} : {8{sampled}};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lastStrobe <= 1'b0;
      sampled <= 1'b0;
      seenEdge <= 1'b0;
      waitCount <= '0;
      dqReg <= 8'h00;
      oeReg <= 8'h00;
    end else begin
      lastStrobe <= lane.strobe;
      if (!lane.enable) begin
        seenEdge <= 1'b0;
        oeReg <= 8'h00;
        waitCount <= '0;
      end else if (rise) begin
        sampled <= lane.clockLevel;
        seenEdge <= 1'b1;
        waitCount <= wlvl_pkg::CountWidth'(wlvl_pkg::FeedbackCycles);
      end else if (waitCount != '0) begin
        waitCount <= waitCount - 1'b1;
      end
      if (lane.enable && seenEdge && waitCount == '0) begin
        dqReg <= feedbackBits;
        oeReg <= {8{lane.outputsOn}};
      end else if (!lane.outputsOn) begin
        // Buffer disable must not wait for a pending feedback update
        oeReg <= 8'h00;
      end
    end
  end
  assign lane.dqOut = dqReg;
  assign lane.dqOe = oeReg;
  chk_feedback_time: assert property (
    @(posedge clk) disable iff (reset)
    rise ##1 (lane.enable && !rise) [*3]
    |=> dqReg[0] == $past(lane.clockLevel, 4))
    else $error("feedback late or wrong");
endmodule // wlvl_lane

/* verilog/ddr3_write_leveling.sv */
// Leveling mode control, termination and feedback of a x16 device.
// Assumes strobe, clock and ODT pins arrive asynchronously.
`timescale 1ns/1ps
module ddr3_write_leveling (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Mode register write
  input wire logic modeWrite,
  input wire logic [2:0] modeSelect,
  input wire logic [15:0] modeValue,
  // Pins
  input wire logic odtPin,
  input wire logic ckLevel,
  input wire logic upper_lane_strobe_pair,
  input wire logic lower_lane_strobe_pair,
  // Outputs
  output logic [15:0] dqOut,
  output logic [15:0] dqOe,
  output logic strobeTermOn,
  output logic dqTermOn,
  output logic levelActive,
  output logic [15:0] mr1Value
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Only the second stage is read; the first may still be settling
  logic [3:0] syncA;
  logic [3:0] syncB;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
    end else begin
      syncA <= {odtPin, ckLevel, upper_lane_strobe_pair,
        lower_lane_strobe_pair};
      syncB <= syncA;
    end
  end
  // ---------------------------------------------------------------
  // Mode state
  // ---------------------------------------------------------------
  wlvl_pkg::level_mode_t mode;
  logic [wlvl_pkg::CountWidth-1:0] modCount;
  wire mr1Write = modeWrite && modeSelect == wlvl_pkg::Mr1Select;
  wire levelReq = modeValue[wlvl_pkg::LevelBit];
  wire odtReady = mode == wlvl_pkg::ModeLevel && modCount == '0;
  // Exit write also clears the level bit in the stored copy
  wire [15:0] exitMask = wlvl_pkg::KeepMask |
    (16'h0001 << wlvl_pkg::LevelBit);
  wire [15:0] qoffMask = 16'h0001 << wlvl_pkg::QoffBit;
  wire [15:0] exitValue = (mr1Value & ~exitMask) |
    (modeValue & exitMask);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= wlvl_pkg::ModeNormal;
      modCount <= '0;
      mr1Value <= wlvl_pkg::MrOne;
    end else begin
      if (modCount != '0)
        modCount <= modCount - 1'b1;
      unique case (mode)
        wlvl_pkg::ModeNormal: begin
          if (mr1Write) begin
            mr1Value <= modeValue;
            if (levelReq) begin
              mode <= wlvl_pkg::ModeLevel;
              modCount <= wlvl_pkg::CountWidth'(wlvl_pkg::ModeDelayCycles);
            end
          end
        end
        wlvl_pkg::ModeLevel: begin
          if (mr1Write && !levelReq) begin
            mr1Value <= exitValue;
            mode <= wlvl_pkg::ModeExit;
            modCount <= wlvl_pkg::CountWidth'(wlvl_pkg::ModeDelayCycles);
          end else if (mr1Write) begin
            mr1Value[wlvl_pkg::QoffBit] <= modeValue[wlvl_pkg::QoffBit];
          end
        end
        wlvl_pkg::ModeExit: begin
          if (modCount == '0)
            mode <= wlvl_pkg::ModeNormal;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Termination and outputs
  // ---------------------------------------------------------------
  wire laneEnable = mode == wlvl_pkg::ModeLevel;
  wire outputsOn = ~mr1Value[wlvl_pkg::QoffBit];
  logic [15:0] laneDq;
  logic [15:0] laneOe;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strobeTermOn <= 1'b0;
      dqTermOn <= 1'b0;
      levelActive <= 1'b0;
      dqOut <= 16'h0000;
      dqOe <= 16'h0000;
    end else begin
      strobeTermOn <= odtReady & syncB[3];
      dqTermOn <= 1'b0;
      levelActive <= laneEnable;
      // One register for both bytes, so all bits of a lane switch together
      dqOut <= laneDq;
      dqOe <= laneOe;
    end
  end
  // ---------------------------------------------------------------
  // Byte lanes
  // ---------------------------------------------------------------
  // Both lanes share one clock sample; each has its own strobe
  lane_if upperIf ();
  lane_if lowerIf ();
  assign upperIf.strobe = syncB[1];
  assign lowerIf.strobe = syncB[0];
  assign upperIf.clockLevel = syncB[2];
  assign lowerIf.clockLevel = syncB[2];
  assign upperIf.enable = laneEnable;
  assign lowerIf.enable = laneEnable;
  assign upperIf.outputsOn = outputsOn;
  assign lowerIf.outputsOn = outputsOn;
  assign laneDq = {upperIf.dqOut, lowerIf.dqOut};
  assign laneOe = {upperIf.dqOe, lowerIf.dqOe};
  wlvl_lane upperLane (
    .clk(clk),
    .reset(reset),
    .lane(upperIf.lane)
  );
  wlvl_lane lowerLane (
    .clk(clk),
    .reset(reset),
    .lane(lowerIf.lane)
  );
  // ---------------------------------------------------------------
  // Assertion helpers
  // ---------------------------------------------------------------
  // Saturates so a long leveling session cannot wrap back to zero
  logic [wlvl_pkg::CountWidth-1:0] levelAge;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      levelAge <= '0;
    end else if (mode != wlvl_pkg::ModeLevel) begin
      levelAge <= '0;
    end else if (levelAge != '1) begin
      levelAge <= levelAge + 1'b1;
    end
  end
  wire [wlvl_pkg::CountWidth-1:0] odtDelay =
    wlvl_pkg::CountWidth'(wlvl_pkg::ModeDelayCycles);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Termination
  chk_no_dq_term: assert property (
    @(posedge clk) disable iff (reset) !dqTermOn)
    else $error("dq termination on");
  chk_term_level: assert property (
    @(posedge clk) disable iff (reset) strobeTermOn |-> levelActive)
    else $error("strobe term outside leveling");
  chk_term_exit: assert property (
    @(posedge clk) disable iff (reset)
    mode == wlvl_pkg::ModeExit |=> !strobeTermOn)
    else $error("strobe term after exit");
  chk_odt_wait: assert property (
    @(posedge clk) disable iff (reset)
    $rose(levelActive) |-> !strobeTermOn [*8])
    else $error("odt honoured early");
  chk_odt_count: assert property (
    @(posedge clk) disable iff (reset) strobeTermOn |-> levelAge > odtDelay)
    else $error("odt before mode delay");
  chk_odt_term: assert property (
    @(posedge clk) disable iff (reset)
    (odtReady && syncB[3]) |=> strobeTermOn)
    else $error("strobe term missing");
  // Mode register copy
  chk_enter_level: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && levelReq && mode == wlvl_pkg::ModeNormal)
    |-> ##2 levelActive) else $error("no entry");
  chk_entry_value: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && mode == wlvl_pkg::ModeNormal)
    |=> mr1Value == $past(modeValue)) else $error("entry value lost");
  chk_level_drop: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && !levelReq && mode == wlvl_pkg::ModeLevel)
    |-> ##2 !levelActive) else $error("no exit");
  chk_exit_bit: assert property (
    @(posedge clk) disable iff (reset)
    mode == wlvl_pkg::ModeExit |-> !mr1Value[wlvl_pkg::LevelBit])
    else $error("level bit kept after exit");
  chk_exit_keep: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && !levelReq && mode == wlvl_pkg::ModeLevel)
    |=> (mr1Value & exitMask) == ($past(modeValue) & exitMask)
    && (mr1Value & ~exitMask) == $past(mr1Value & ~exitMask))
    else $error("exit bits");
  chk_other_reg: assert property (
    @(posedge clk) disable iff (reset)
    (modeWrite && !mr1Write) |=> $stable(mr1Value))
    else $error("other register changed copy");
  chk_exit_ignore: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && mode == wlvl_pkg::ModeExit) |=> $stable(mr1Value))
    else $error("write taken during exit delay");
  chk_qoff_level: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && levelReq && mode == wlvl_pkg::ModeLevel)
    |=> mr1Value[wlvl_pkg::QoffBit] == $past(modeValue[wlvl_pkg::QoffBit]))
    else $error("buffer bit not taken");
  chk_mr1_hold: assert property (
    @(posedge clk) disable iff (reset)
    (mr1Write && levelReq && mode == wlvl_pkg::ModeLevel)
    |=> (mr1Value & ~qoffMask) == $past(mr1Value & ~qoffMask))
    else $error("level write touched other bits");
  // Feedback outputs
  chk_qoff_mute: assert property (
    @(posedge clk) disable iff (reset)
    mr1Value[wlvl_pkg::QoffBit] |-> ##2 dqOe == 16'h0000)
    else $error("outputs not disabled");
  chk_exit_quiet: assert property (
    @(posedge clk) disable iff (reset)
    mode == wlvl_pkg::ModeExit |-> ##2 dqOe == 16'h0000)
    else $error("dq driven after exit");
  chk_oe_level: assert property (
    @(posedge clk) disable iff (reset)
    dqOe != 16'h0000 |-> levelActive || $past(levelActive))
    else $error("dq driven outside leveling");
  chk_normal_mute: assert property (
    @(posedge clk) disable iff (reset)
    (mode == wlvl_pkg::ModeNormal && $past(mode) == wlvl_pkg::ModeNormal)
    |-> dqOe == 16'h0000) else $error("dq driven in normal mode");
  chk_other_low: assert property (
    @(posedge clk) disable iff (reset) dqOut[7:1] == 7'h00)
    else $error("lower non-prime bit high");
  chk_upper_low: assert property (
    @(posedge clk) disable iff (reset) dqOut[15:9] == 7'h00)
    else $error("upper non-prime bit high");
endmodule // ddr3_write_leveling

/* sim/wlvl_ctrl_model.sv */
// Controller model: free clock, ODT, strobes, delay sweep.
// Assumes the device samples pins on clk.
`timescale 1ns/1ps
module wlvl_ctrl_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic odtPin,
  output logic ckLevel,
  output logic upper_lane_strobe_pair,
  output logic lower_lane_strobe_pair,
  // Feedback
  input wire logic [15:0] dqOut
);
  logic [3:0] phase = 4'h0;
  logic [1:0] locked = 2'b00;
  initial begin
    odtPin = 0;
    ckLevel = 0;
    upper_lane_strobe_pair = 0;
    lower_lane_strobe_pair = 0;
  end
  // CK runs free, 16 cycles a period
  always @(posedge clk) begin
    #1 phase = phase + 4'h1;
    ckLevel = phase[3];
  end
  task automatic setOdt(input logic v);
    odtPin = v;
  endtask
  // ------------------------------
  // One lane swept on its own
  // ------------------------------
  task automatic levelLane(input int lane, output logic [16:0] seq,
      output logic [6:0] rest, output int at);
    logic prev;
    logic fb;
    prev = 1;
    seq = '0;
    rest = '0;
    at = -1;
    for (int d = 0; d < 40 && at < 0; d++) begin
      @(posedge ckLevel);
      repeat (d) @(posedge clk);
      if (d > 0) #1;
      if (lane == 1) upper_lane_strobe_pair = 1;
      else lower_lane_strobe_pair = 1;
      repeat (3) @(posedge clk);
      #1 upper_lane_strobe_pair = 0;
      lower_lane_strobe_pair = 0;
      // Waits out feedback delay and skew
      repeat (12) @(posedge clk);
      #1 fb = dqOut[lane*8];
      rest = rest | dqOut[lane*8+1 +: 7];
      if (d < 17) seq[d] = fb;
      if (!prev && fb) at = d;
      prev = fb;
    end
    if (at >= 0) locked[lane] = 1;
  endtask
endmodule // wlvl_ctrl_model

/* sim/testbench.sv */
// Self-checking bench of the leveling block.
// Assumes the controller model drives the pins.
`timescale 1ns/1ps
module testbench;
  logic clk, reset, modeWrite, odtPin, ckLevel, upStb, lowStb;
  logic strobeTermOn, dqTermOn, levelActive;
  logic [2:0] modeSelect;
  logic [15:0] modeValue, dqOut, dqOe, mr1Value, expMr;
  logic [16:0] seq;
  logic [6:0] rest;
  int num_errors = 0, num_checks = 0, cycles = 0, at;
  ddr3_write_leveling dut (.clk(clk), .reset(reset),
    .modeWrite(modeWrite), .modeSelect(modeSelect),
    .modeValue(modeValue), .odtPin(odtPin), .ckLevel(ckLevel),
    .upper_lane_strobe_pair(upStb), .lower_lane_strobe_pair(lowStb),
    .dqOut(dqOut), .dqOe(dqOe), .strobeTermOn(strobeTermOn),
    .dqTermOn(dqTermOn), .levelActive(levelActive),
    .mr1Value(mr1Value));
  wlvl_ctrl_model ctrl (.clk(clk), .odtPin(odtPin), .ckLevel(ckLevel),
    .upper_lane_strobe_pair(upStb), .lower_lane_strobe_pair(lowStb),
    .dqOut(dqOut));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic mrs(input logic [2:0] sel, input logic [15:0] val);
    @(posedge clk);
    #1 modeWrite = 1;
    modeSelect = sel;
    modeValue = val;
    cyc(1);
    modeWrite = 0;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well above two full sweeps
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      summarize();
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    reset = 1;
    modeWrite = 0;
    modeSelect = 0;
    modeValue = 0;
    cyc(8);
    reset = 0;
    check({levelActive, mr1Value}, 32'h0000_0000);
    check(dqOe, 32'h0000_0000);
    mrs(3'h2, 16'h0080);
    cyc(3);
    check(levelActive, 32'h0000_0000);
    mrs(3'h1, 16'h0080);
    cyc(2);
    check({levelActive, mr1Value}, 32'h0001_0080);
    ctrl.setOdt(1);
    cyc(4);
    check(strobeTermOn, 32'h0000_0000);
    ctrl.setOdt(0);
    cyc(12);
    ctrl.setOdt(1);
    cyc(5);
    check({strobeTermOn, dqTermOn}, 32'h0000_0002);
    for (int ln = 1; ln >= 0; ln--) begin
      ctrl.levelLane(ln, seq, rest, at);
      check(seq, 32'h0001_00FF);
      check(rest, 32'h0000_0000);
      check(at, 32'h0000_0010);
    end
    check(dqOe, 32'h0000_FFFF);
    mrs(3'h1, 16'h1080);
    cyc(3);
    check({dqOe, mr1Value}, 32'h0000_1080);
    mrs(3'h1, 16'h0080);
    ctrl.setOdt(0);
    cyc(5);
    check({strobeTermOn, dqTermOn}, 32'h0000_0000);
    expMr = (16'h1A6E & wlvl_pkg::KeepMask) |
      (16'h0080 & ~wlvl_pkg::KeepMask & 16'hFF7F);
    mrs(3'h1, 16'h1A6E);
    cyc(2);
    check({levelActive, dqOe}, 32'h0000_0000);
    check(mr1Value, expMr);
    mrs(3'h1, 16'h0080);
    cyc(20);
    check({levelActive, mr1Value}, {16'h0000, expMr});
    // This device as a rank not being leveled
    mrs(3'h1, 16'h1000);
    cyc(2);
    check({levelActive, mr1Value}, 32'h0000_1000);
    check(dqOe, 32'h0000_0000);
    check(ctrl.locked, 32'h0000_0003);
    summarize();
  end
endmodule // testbench
